/* File: dv/ext_clk_src.sv */
`timescale 1ns/1ps
`default_nettype none

// ----
// external count source
// ----
module ext_clk_src
(
  // clock
  input wire logic clock,
  // count pin
  output logic pin
);
  initial pin = 1'h0;
  task automatic drive(input logic lvl, input int gap);
    @(posedge clock);
    pin <= lvl;
    repeat (gap) @(posedge clock);
  endtask : drive
endmodule : ext_clk_src

`default_nettype wire

/* File: dv/frc_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module frc_sva
  import frc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // timer
  input wire logic cpu_global_mask,
  input wire logic halt_mode,
  input wire logic [15:0] counter_value,
  input wire logic timer_irq
);
  // ----
  // properties
  // ----
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken;
    arvalid && arready;
  endsequence
  chk_reset_count: assert property (
    $past(sys_rst) |-> counter_value == COUNT_RESET) else $error("count not at reset value");
  chk_count_step: assert property (
    $changed(counter_value) |->
    counter_value == $past(counter_value) + 16'h0001 || counter_value == COUNT_RESET)
    else $error("count jumped");
  chk_halt_freeze: assert property (
    halt_mode [*3] |-> $stable(counter_value) || counter_value == COUNT_RESET)
    else $error("count moved in halt");
  chk_irq_masked: assert property (
    cpu_global_mask [*2] |-> !timer_irq) else $error("irq while masked");
  chk_write_resp: assert property (
    wr_taken |=> ##1 bvalid) else $error("no write response");
  chk_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
  chk_read_resp: assert property (
    rd_taken |=> rvalid && rdata[31:8] == 24'h000000) else $error("bad read response");
  chk_rdata_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
endmodule : frc_sva

bind free_running_counter frc_sva sva_u (.clock, .sys_rst, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
  .cpu_global_mask, .halt_mode, .counter_value, .timer_irq);

`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import frc_pkg::*;
;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic cpu_global_mask = 1'h0;
  logic halt_mode = 1'h1;
  logic awready, wready, bvalid, arready, rvalid, ext_clock_pin, timer_irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] counter_value, c0;
  logic [15:0] per [3] = '{16'h0010, 16'h0020, 16'h0008};
  logic [33:0] expq [$];
  logic [31:0] rnd = 32'h59F8;
  int err_count = 0;
  int n_tests = 0;

  initial forever #5 clock = ~clock;

  free_running_counter dut_u (.clock(clock), .sys_rst(sys_rst), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h1),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_clock_pin(ext_clock_pin),
    .cpu_global_mask(cpu_global_mask), .halt_mode(halt_mode),
    .counter_value(counter_value), .timer_irq(timer_irq));
  ext_clk_src src_u (.clock(clock), .pin(ext_clock_pin));

  // ----
  // tasks
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic hung;
    err_count++;
    tally_and_finish();
  endtask : hung

  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic ab, wb, bd;
    logic [1:0] br;
    bd = 1'h0;
    rnd = lfsr(rnd);
    @(posedge clock);
    awaddr <= a;
    wdata <= {rnd[31:8], d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (int i = 0; i < 64 && !bd; i++)
    begin
      @(negedge clock);
      ab = awvalid && awready;
      wb = wvalid && wready;
      bd = bvalid && bready;
      br = bresp;
      @(posedge clock);
      if (ab) awvalid <= 1'h0;
      if (wb) wvalid <= 1'h0;
      bready <= (i >= rnd[1:0]) && !bd;
    end
    if (!bd)
      hung();
    check({32'h0, br}, {32'h0, er});
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic ak, rv;
    rv = 1'h0;
    rnd = lfsr(rnd);
    expq.push_back({er, 24'h0, d});
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    for (int i = 0; i < 64 && !rv; i++)
    begin
      @(negedge clock);
      ak = arvalid && arready;
      rv = rvalid && rready;
      @(posedge clock);
      if (ak) arvalid <= 1'h0;
      rready <= (i >= rnd[1:0]) && !rv;
    end
    if (!rv)
      hung();
  endtask : rd

  task automatic pulse(input int n);
    repeat (n)
    begin
      src_u.drive(1'h1, 5);
      src_u.drive(1'h0, 9);
    end
  endtask : pulse

  task automatic irq_after(input logic m, input logic v);
    @(posedge clock);
    cpu_global_mask <= m;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check({33'h0, timer_irq}, {33'h0, v});
  endtask : irq_after

  always @(negedge clock)
    if (rvalid && rready)
      check({rresp, rdata}, expq.pop_front());

  // ----
  // scenarios
  // ----
  initial
  begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'h0;
    rd(OFS_COUNT_HIGH, 8'hFF);
    rd(OFS_COUNT_LOW, 8'hFC);
    rd(OFS_ALT_HIGH, 8'hFF);
    rd(OFS_ALT_LOW, 8'hFC);
    wr(OFS_CONTROL_TWO, 8'h13);
    wr(OFS_ALT_LOW, 8'h00);
    halt_mode <= 1'h0;
    pulse(3);
    rd(OFS_COUNT_HIGH, 8'hFF);
    pulse(2);
    rd(OFS_COUNT_HIGH, 8'h00);
    rd(OFS_COUNT_LOW, 8'hFF);
    rd(OFS_COUNT_LOW, 8'h01);
    rd(OFS_STATUS, 8'h20);
    rd(OFS_ALT_LOW, 8'h01);
    rd(OFS_STATUS, 8'h20);
    rd(OFS_COUNT_LOW, 8'h01);
    rd(OFS_STATUS, 8'h00);
    wr(OFS_CONTROL_TWO, 8'h03);
    src_u.drive(1'h1, 9);
    rd(OFS_COUNT_LOW, 8'h01);
    src_u.drive(1'h0, 9);
    rd(OFS_COUNT_LOW, 8'h02);
    halt_mode <= 1'h1;
    pulse(2);
    halt_mode <= 1'h0;
    rd(OFS_COUNT_LOW, 8'h02);
    pulse(1);
    rd(OFS_COUNT_LOW, 8'h03);
    wr(OFS_CONTROL_ONE, 8'h80);
    wr(OFS_COUNT_LOW, 8'h5A);
    pulse(4);
    irq_after(1'h0, 1'h1);
    irq_after(1'h1, 1'h0);
    irq_after(1'h0, 1'h1);
    rd(OFS_STATUS, 8'h20);
    wr(OFS_COUNT_LOW, 8'hA5);
    irq_after(1'h0, 1'h0);
    for (int k = 0; k < 3; k++)
    begin
      wr(OFS_CONTROL_TWO, k[7:0]);
      repeat (16) @(negedge clock);
      c0 = counter_value;
      repeat (64) @(negedge clock);
      check({18'h0, counter_value - c0}, {18'h0, per[k]});
    end
    rd(5'h1C, 8'h00, RESP_SLVERR);
    wr(5'h1C, 8'h00, RESP_SLVERR);
    @(posedge clock);
    halt_mode <= 1'h1;
    sys_rst <= 1'h1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'h0;
    rd(OFS_COUNT_HIGH, 8'hFF);
    rd(OFS_COUNT_LOW, 8'hFC);
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire

/* File: rtl/frc_pkg.sv */
package frc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CONTROL_ONE = 5'h00;
  localparam logic [4:0] OFS_CONTROL_TWO = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_COUNT_HIGH = 5'h0C;
  localparam logic [4:0] OFS_COUNT_LOW = 5'h10;
  localparam logic [4:0] OFS_ALT_HIGH = 5'h14;
  localparam logic [4:0] OFS_ALT_LOW = 5'h18;

  typedef enum logic [2:0] {
    SEL_CONTROL_ONE = 3'h0,
    SEL_CONTROL_TWO = 3'h1,
    SEL_STATUS = 3'h2,
    SEL_COUNT_HIGH = 3'h3,
    SEL_COUNT_LOW = 3'h4,
    SEL_ALT_HIGH = 3'h5,
    SEL_ALT_LOW = 3'h6,
    SEL_NONE = 3'h7
  } reg_sel_e;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int IRQ_ENABLE_BIT = 7;
  localparam int EDGE_SELECT_BIT = 4;
  localparam int CLOCK_SELECT_LSB = 0;
  localparam int OVERFLOW_BIT = 5;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'hFFFC;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // clock source codes and prescale masks
  // ----------------------------------------------------------------
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : frc_pkg

/* File: rtl/free_running_counter.sv */
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - sixteen-bit free up-counter, two byte views
// - tick from clock divided 2/4/8 or pin
// - both select bits one picks external pin
// - edge bit picks rising or falling pin edge
// - pin increments aligned to the system clock
// - low byte writes reload FFFCh
// - reset starts count at FFFCh always
// - alternate view, never clears overflow flag
// - high byte read latches low byte
// - latched low byte frozen until low read
// - after sequence, low read gives live byte
// - wrap FFFFh to 0000h sets overflow flag
// - irq when enabled and global mask clear
// - flag clears on status read then low access
// - wait mode changes nothing
// - halt freezes count, resumes afterwards
// - unbonded pin reads as one
module free_running_counter
  import frc_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W,
  parameter bit PIN_BONDED = 1'b1
)
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // axi4-lite write address
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pins and cpu state
  input wire logic ext_clock_pin,
  input wire logic cpu_global_mask,
  input wire logic halt_mode,
  // to the rest of the timer
  output logic [15:0] counter_value,
  output logic timer_irq
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // the decoder needs every offset bit of the map
  if (ADDR_WIDTH < ADDR_W)
  begin : g_addr_too_narrow
    $error("ADDR_WIDTH too small for the register map");
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic reg_sel_e decode(input logic [ADDR_WIDTH-1:0] addr);
    reg_sel_e sel;
    logic [ADDR_WIDTH-1:0] upper;
    sel = SEL_NONE;
    upper = addr >> ADDR_W;
    if (upper == '0)
    begin
      unique case (addr[ADDR_W-1:0])
        OFS_CONTROL_ONE: sel = SEL_CONTROL_ONE;
        OFS_CONTROL_TWO: sel = SEL_CONTROL_TWO;
        OFS_STATUS: sel = SEL_STATUS;
        OFS_COUNT_HIGH: sel = SEL_COUNT_HIGH;
        OFS_COUNT_LOW: sel = SEL_COUNT_LOW;
        OFS_ALT_HIGH: sel = SEL_ALT_HIGH;
        OFS_ALT_LOW: sel = SEL_ALT_LOW;
        default: sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction : decode

  // either view of the low byte
  function automatic logic is_low_view(input reg_sel_e sel);
    return sel == SEL_COUNT_LOW || sel == SEL_ALT_LOW;
  endfunction : is_low_view

  // either view of the high byte
  function automatic logic is_high_view(input reg_sel_e sel);
    return sel == SEL_COUNT_HIGH || sel == SEL_ALT_HIGH;
  endfunction : is_high_view

  logic aw_held;
  logic w_held;
  logic [ADDR_WIDTH-1:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;
  logic do_write;
  logic rd_take;
  reg_sel_e wr_sel;
  reg_sel_e rd_sel;

  logic [7:0] control_one;
  logic [7:0] control_two;
  logic overflow_flag;
  logic clear_armed;
  logic [7:0] low_buffer;
  logic seq_open;
  logic low_write;
  logic low_read;
  logic low_access;
  logic wrap;
  logic status_read;
  logic high_read;

  tick_if tk ();

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data may arrive in either order
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;
  assign wr_sel = decode(aw_addr_q);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (awvalid && awready)
    begin
      aw_held <= 1'b1;
      aw_addr_q <= awaddr;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      w_held <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      w_held <= 1'b1;
      w_byte_q <= wdata[7:0];
      w_lane_q <= wstrb[0];
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      control_one <= CONTROL_RESET;
      control_two <= CONTROL_RESET;
    end
    else if (do_write && w_lane_q)
    begin
      if (wr_sel == SEL_CONTROL_ONE)
        control_one <= w_byte_q;
      if (wr_sel == SEL_CONTROL_TWO)
        control_two <= w_byte_q;
    end
  end

  assign tk.clock_select = control_two[CLOCK_SELECT_LSB +: 2];
  assign tk.ext_edge_select = control_two[EDGE_SELECT_BIT];
  // only halt gates the tick; wait mode has no input here
  assign tk.halt = halt_mode;

  tick_source #(
    .PIN_BONDED(PIN_BONDED)
  ) u_tick (
    .clock(clock),
    .sys_rst(sys_rst),
    .ext_clock_pin(ext_clock_pin),
    .tk(tk)
  );

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // any write to either low byte reloads, whatever the strobes
  assign low_write = do_write && is_low_view(wr_sel);
  assign wrap = tk.tick && !low_write && counter_value == COUNT_MAX;

  // reload outranks a tick in the same cycle
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      counter_value <= COUNT_RESET;
    else if (low_write)
      counter_value <= COUNT_RESET;
    else if (tk.tick)
      counter_value <= counter_value + 16'h0001;
  end

  // ----------------------------------------------------------------
  // overflow flag and its two-step clear
  // ----------------------------------------------------------------
  // only the main low byte counts as the second step
  assign low_access = (rd_take && rd_sel == SEL_COUNT_LOW) ||
                      (do_write && wr_sel == SEL_COUNT_LOW);
  assign status_read = rd_take && rd_sel == SEL_STATUS;

  // a wrap in the clearing cycle wins
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      overflow_flag <= 1'b0;
    else if (wrap)
      overflow_flag <= 1'b1;
    else if (clear_armed && low_access)
      overflow_flag <= 1'b0;
  end

  // a new wrap needs a fresh status read
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      clear_armed <= 1'b0;
    else if (wrap || (clear_armed && low_access))
      clear_armed <= 1'b0;
    else if (status_read && overflow_flag)
      clear_armed <= 1'b1;
  end

  // level request, stays pending while masked
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      timer_irq <= 1'b0;
    else
      timer_irq <= overflow_flag && control_one[IRQ_ENABLE_BIT] && !cpu_global_mask;
  end

  // ----------------------------------------------------------------
  // coherent sixteen-bit read
  // ----------------------------------------------------------------
  assign low_read = rd_take && is_low_view(rd_sel);
  assign high_read = rd_take && is_high_view(rd_sel);

  // high reads while open keep the first latch

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      seq_open <= 1'b0;
      low_buffer <= 8'h00;
    end
    else if (low_read)
      seq_open <= 1'b0;
    else if (high_read && !seq_open)
    begin
      seq_open <= 1'b1;
      low_buffer <= counter_value[7:0];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  // one read in flight; arready drops while rvalid stands
  assign arready = !rvalid;
  assign rd_take = arvalid && arready;
  assign rd_sel = decode(araddr);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
      unique case (rd_sel)
        SEL_CONTROL_ONE: rdata[7:0] <= control_one;
        SEL_CONTROL_TWO: rdata[7:0] <= control_two;
        SEL_STATUS: rdata[OVERFLOW_BIT] <= overflow_flag;
        SEL_COUNT_HIGH, SEL_ALT_HIGH: rdata[7:0] <= counter_value[15:8];
        SEL_COUNT_LOW, SEL_ALT_LOW:
          rdata[7:0] <= seq_open ? low_buffer : counter_value[7:0];
        SEL_NONE: rresp <= RESP_SLVERR;
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

endmodule : free_running_counter

`default_nettype wire

/* File: rtl/tick_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface tick_if;
  logic [1:0] clock_select;
  logic ext_edge_select;
  logic halt;
  logic tick;
  modport source (
    input clock_select,
    input ext_edge_select,
    input halt,
    output tick
  );
  modport sink (
    output clock_select,
    output ext_edge_select,
    output halt,
    input tick
  );
endinterface : tick_if

`default_nettype wire

/* File: rtl/tick_source.sv */
`timescale 1ns/1ps
`default_nettype none

module tick_source
  import frc_pkg::*;
#(
  parameter bit PIN_BONDED = 1'b1
)
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // external clock pin
  input wire logic ext_clock_pin,
  // count enable to the counter
  tick_if.source tk
);

  logic pin_seen;
  logic sync_first;
  logic sync_second;
  logic sync_prev;
  logic ext_edge;
  logic [2:0] div_count;
  logic [2:0] div_mask;

  assign pin_seen = PIN_BONDED ? ext_clock_pin : 1'b1;

  // ----------------------------------------------------------------
  // external pin synchroniser and edge detector
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sync_first <= 1'b1;
      sync_second <= 1'b1;
      sync_prev <= 1'b1;
    end
    else
    begin
      sync_first <= pin_seen;
      sync_second <= sync_first;
      sync_prev <= sync_second;
    end
  end

  // edge select picks rising or falling transition
  assign ext_edge = tk.ext_edge_select ? (sync_second & ~sync_prev)
                                       : (~sync_second & sync_prev);

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (tk.clock_select)
      CLK_DIV2: div_mask = DIV2_MASK;
      CLK_DIV4: div_mask = DIV4_MASK;
      CLK_DIV8: div_mask = DIV8_MASK;
      CLK_EXT: div_mask = DIV8_MASK;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      div_count <= 3'h0;
    else if (!tk.halt)
      div_count <= div_count + 3'h1;
  end

  // one-cycle tick; frozen while halted
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      tk.tick <= 1'b0;
    else if (tk.halt)
      tk.tick <= 1'b0;
    else if (tk.clock_select == CLK_EXT)
      tk.tick <= ext_edge;
    else
      tk.tick <= (div_count & div_mask) == div_mask;
  end

endmodule : tick_source

`default_nettype wire
